// File: src/float_alu_params.svh
/*
 * constants for the floating-point alu: operand layout, flag positions,
 * mode bit positions and special values.
 * assumes 40-bit extended single-precision operands.
 */
`ifndef FLOAT_ALU_PARAMS_SVH
`define FLOAT_ALU_PARAMS_SVH
// ****************************************
// operand layout
// ****************************************
`define FA_WIDTH        40
`define FA_EXP_BIAS     10'sh07f
`define FA_EXP_MAXB     8'hff
`define FA_ALL_ONES     40'hff_ffff_ffff
`define FA_LARGEST_NORMAL_VALUE_MAG 39'h7f_7fff_ffff
`define FA_INF_MAG      39'h7f_8000_0000
// ****************************************
// status word positions
// ****************************************
`define FA_ST_ZERO      0
`define FA_ST_OVF       1
`define FA_ST_NEG       2
`define FA_ST_CARRY     3
`define FA_ST_SIGN      4
`define FA_ST_INV       5
`define FA_ST_UNF       6
`define FA_HIST_LO      24
`define FA_HIST_HI      31
// ****************************************
// mode control word positions
// ****************************************
`define FA_MODE_TRUNC   0
`define FA_MODE_RND32   1
`endif

// File: src/float_alu_pkg.sv
/*
 * types for the floating-point alu: opcodes, pipeline states, operand
 * and flag carriers. assumes the params header for the widths.
 */
`default_nettype none
package float_alu_pkg;
  // operation codes
  typedef enum logic [3:0] {
    op_add = 4'h0, op_sub = 4'h1, op_abs_add = 4'h2, op_abs_sub = 4'h3,
    op_avg = 4'h4, op_comp = 4'h5, op_neg = 4'h6, op_abs = 4'h7,
    op_pass = 4'h8, op_round = 4'h9
  } fp_op_e;
  // result valid state, one-hot
  typedef enum logic [1:0] {st_idle = 2'b01, st_done = 2'b10} alu_state_e;
  // flag group
  typedef struct packed {
    logic unf; logic inv; logic sgn; logic carry; logic neg; logic ovf; logic zero;
  } alu_flags_s;
  // request group
  typedef struct packed {
    logic        valid;
    fp_op_e      op;
    logic [39:0] x;
    logic [39:0] y;
  } alu_req_s;
endpackage : float_alu_pkg
`default_nettype wire

// File: src/float_alu_arith_compare.sv
/*
 * floating-point alu slice: add, subtract, absolute sum/difference,
 * average, compare, negate, abs, pass and round, with status flags and the
 * compare history. assumes the sequencer issues one request a cycle and the
 * register file takes the result one cycle later.
 */
`default_nettype none
`include "float_alu_params.svh"
// Contract
// - add/subtract, normalize, write destination
// - round nearest or truncate, 32/40 bit
// - overflow: signed infinity or largest normal
// - abs ops give magnitude, positive infinity; an all-ones answer stays all ones
// - denormals in and out become zero
// - nan input gives all ones
// - zero flag on zero or denormal
// - underflow flag on denormal result
// - overflow flag when exponent exceeds 127
// - add invalid: nan or opposite infinities
// - subtract invalid: nan or like infinities
// - negative follows sign except on an all-ones answer; carry, sign cleared
// - average halves sum before rounding
// - compare sets zero/negative, no write
// - compare shifts eight-entry history right
// - top history bit is x greater
// - compare invalid on nan, clears others
// - negate flips sign, zero flag
// - abs clears sign, sets input sign
// - pass copies operand, zero flag
// - round to 32 bits by mode
// - single-operand invalid on nan
module float_alu_arith_compare (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // request from sequencer
  input  wire float_alu_pkg::alu_req_s  req,
  // mode control word bits
  input  wire logic [1:0]               mode_control_word,
  // result to register file
  output logic                          dest_we,
  output logic [39:0]                   dest_reg,
  // status
  output float_alu_pkg::alu_flags_s     flags,
  output logic [7:0]                    compare_history
);
  import float_alu_pkg::*;

  // ****************************************
  // operand decode
  // ****************************************
  logic        sx, sy;          // signs
  logic [7:0]  ex, ey;          // biased exponents
  logic [31:0] fx, fy;          // fractions, 23 plus 8 extension bits, padded
  logic        nan_x, nan_y, inf_x, inf_y, zx, zy;
  assign sx = req.x[39];
  assign sy = req.y[39];
  assign ex = req.x[38:31];
  assign ey = req.y[38:31];
  assign fx = {1'b0, req.x[30:0]};
  assign fy = {1'b0, req.y[30:0]};
  assign nan_x = (ex == `FA_EXP_MAXB) && (fx != 32'h0);
  assign nan_y = (ey == `FA_EXP_MAXB) && (fy != 32'h0);
  assign inf_x = (ex == `FA_EXP_MAXB) && (fx == 32'h0);
  assign inf_y = (ey == `FA_EXP_MAXB) && (fy == 32'h0);
  // exponent zero means zero or denormal: both are flushed
  assign zx = (ex == 8'h00);
  assign zy = (ey == 8'h00);

  // ****************************************
  // combinational datapath
  // ****************************************
  logic [39:0] res_c;
  logic        we_c;
  alu_flags_s  fl_c;
  logic        cmp_c;

  // add/sub core, rounding, special cases in one pass
  always_comb begin
    logic        eff_sy, big_s, sml_s, rs, trunc, r32, nan_any;
    logic [7:0]  big_e, sml_e;
    logic [34:0] big_m, sml_m, sum;  // 1.31 mantissa plus guard/round/sticky
    logic [34:0] sh;
    logic [5:0]  lz;
    logic signed [10:0] re;
    logic [34:0] nm;
    logic [31:0] kept;               // hidden + 31 fraction
    logic [32:0] rnd;
    logic        rbit, stk, half;
    logic [7:0]  d;
    res_c  = 40'h0;
    we_c   = 1'b0;
    fl_c   = '0;
    cmp_c  = 1'b0;
    // every local starts from a known value so no latch is inferred
    eff_sy = 1'b0;
    big_s  = 1'b0;
    sml_s  = 1'b0;
    rs     = 1'b0;
    big_e  = 8'h0;
    sml_e  = 8'h0;
    big_m  = '0;
    sml_m  = '0;
    sum    = '0;
    sh     = '0;
    lz     = 6'h0;
    re     = '0;
    nm     = '0;
    kept   = '0;
    rnd    = '0;
    rbit   = 1'b0;
    stk    = 1'b0;
    half   = 1'b0;
    d      = 8'h0;
    trunc   = mode_control_word[`FA_MODE_TRUNC];
    r32     = mode_control_word[`FA_MODE_RND32] || (req.op == op_round);
    nan_any = nan_x || ((req.op inside {op_add, op_sub, op_abs_add, op_abs_sub, op_avg,
                                        op_comp}) && nan_y);
    unique case (req.op)
      op_add, op_sub, op_abs_add, op_abs_sub, op_avg: begin
        we_c   = 1'b1;
        eff_sy = sy ^ (req.op inside {op_sub, op_abs_sub});
        // invalid per operation sign sense
        fl_c.inv = nan_x || nan_y || (inf_x && inf_y && (sx != eff_sy));
        if (nan_any) begin
          res_c = `FA_ALL_ONES;
        end else if (inf_x || inf_y) begin
          rs    = inf_x ? sx : eff_sy;
          res_c = (inf_x && inf_y && sx != eff_sy) ? `FA_ALL_ONES : {rs, `FA_INF_MAG};
          fl_c.ovf = 1'b0;
        end else begin
          // order by magnitude, denormals already zero
          if ({ex, fx} >= {ey, fy}) begin
            // x has the larger magnitude
            big_e = ex;
            big_s = sx;
            big_m = zx ? '0 : {1'b1, fx[30:0], 3'b000};
            sml_e = ey;
            sml_s = eff_sy;
            sml_m = zy ? '0 : {1'b1, fy[30:0], 3'b000};
          end else begin
            // y has the larger magnitude
            big_e = ey;
            big_s = eff_sy;
            big_m = zy ? '0 : {1'b1, fy[30:0], 3'b000};
            sml_e = ex;
            sml_s = sx;
            sml_m = zx ? '0 : {1'b1, fx[30:0], 3'b000};
          end
          d  = big_e - sml_e;
          sh = (d > 8'd34) ? 35'h0 : (sml_m >> d);
          // sticky keeps bits shifted out
          sh[0] = sh[0] | ((d > 8'd34) ? (sml_m != '0)
                                      : ((sml_m & ~(35'h7_ffff_ffff << d)) != '0));
          rs = big_s;
          if (big_s == sml_s) sum = big_m + sh;
          else sum = big_m - sh;
          // carry out of 35 bits: detect by width extension
          re = $signed({3'b000, big_e});
          if ((big_s == sml_s) && ({1'b0, big_m} + {1'b0, sh}) > 36'h7_ffff_ffff) begin
            stk = sum[0];
            sum = {1'b1, sum[34:1]};
            sum[0] = sum[0] | stk;
            re = re + 11'sd1;
          end
          // normalize left
          lz = 6'd0;
          for (int i = 34; i >= 0; i--) if (sum[i] && lz == 6'd0 && i != 34) lz = 6'(34 - i);
          if (sum[34]) lz = 6'd0;
          nm = sum << lz;
          re = re - 11'($unsigned(lz));
          if (req.op == op_avg) re = re - 11'sd1;
          // rounding at 32 or 40 bit boundary
          if (r32) begin
            kept = {nm[34:11], 8'h00};
            rbit = nm[10];
            stk  = nm[9:0] != '0;
            half = nm[11];
          end else begin
            kept = nm[34:3];
            rbit = nm[2];
            stk  = nm[1:0] != '0;
            half = nm[3];
          end
          rnd = {1'b0, kept};
          if (!trunc && rbit && (stk || half)) rnd = rnd + (r32 ? 33'h100 : 33'h1);
          if (rnd[32]) begin
            rnd = rnd >> 1;
            re  = re + 11'sd1;
          end
          if (sum == '0) begin
            res_c = 40'h0; // exact cancellation gives plus zero
            fl_c.zero = 1'b1;
          end else if (re >= 11'sd255) begin
            fl_c.ovf = 1'b1;
            res_c = {rs, trunc ? `FA_LARGEST_NORMAL_VALUE_MAG : `FA_INF_MAG};
          end else if (re <= 11'sd0) begin
            fl_c.unf  = 1'b1;
            fl_c.zero = 1'b1;
            res_c = {rs, 39'h0};
          end else begin
            res_c = {rs, re[7:0], rnd[30:0]};
          end
        end
        // abs ops clear the sign, but an all-ones answer stays all ones
        if (req.op inside {op_abs_add, op_abs_sub}) begin
          res_c[39] = (res_c == `FA_ALL_ONES);
        end
        fl_c.neg = (res_c != `FA_ALL_ONES) && res_c[39];
      end
      op_comp: begin
        // signed-magnitude compare with zeros equal
        fl_c.inv = nan_x || nan_y;
        if ((zx && zy) || (req.x == req.y)) fl_c.zero = !fl_c.inv;
        else if (zx) fl_c.neg = !sy;
        else if (zy) fl_c.neg = sx;
        else if (sx != sy) fl_c.neg = sx;
        else fl_c.neg = sx ? ({ex, fx} > {ey, fy}) : ({ex, fx} < {ey, fy});
        if (fl_c.inv) fl_c.neg = 1'b0;
        // a nan compare clears both flags, so it records x greater
        cmp_c = !fl_c.zero && !fl_c.neg;
      end
      op_neg, op_abs, op_pass, op_round: begin
        we_c     = 1'b1;
        fl_c.inv = nan_x;
        if (nan_x) res_c = `FA_ALL_ONES;
        else if (zx) res_c = {sx, 39'h0};
        else res_c = req.x;
        if (req.op == op_neg && !nan_x) res_c[39] = ~sx;
        if (req.op == op_abs && !nan_x) begin
          res_c[39] = 1'b0;
          fl_c.sgn  = sx;
        end
        if (req.op == op_round && !nan_x && !zx && !inf_x) begin
          // round 40 to 32 bits by mode only
          rnd = {1'b0, 1'b1, req.x[30:0]};
          if (!trunc && req.x[7] && (req.x[6:0] != 7'h0 || req.x[8])) rnd = rnd + 33'h100;
          rnd[7:0] = 8'h00;
          re = $signed({3'b000, ex});
          if (rnd[32]) begin
            rnd = rnd >> 1;
            re  = re + 11'sd1;
          end
          if (re >= 11'sd255) begin
            fl_c.ovf = 1'b1;
            res_c = {sx, trunc ? `FA_LARGEST_NORMAL_VALUE_MAG : `FA_INF_MAG};
          end else begin
            res_c = {sx, re[7:0], rnd[30:0]};
          end
        end
        fl_c.zero = !nan_x && (res_c[38:0] == 39'h0);
        fl_c.neg  = !nan_x && res_c[39];
      end
      default: begin
        res_c = 40'h0;
      end
    endcase
  end

  // ****************************************
  // result register
  // ****************************************
  // output stage, one cycle of latency
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dest_we  <= 1'b0;
      dest_reg <= 40'h0;
    end else begin
      dest_we  <= req.valid && we_c;
      if (req.valid && we_c) dest_reg <= res_c;
    end
  end

  // status flags, all ops rewrite them; carry never set
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) flags <= '0;
    else if (req.valid) flags <= fl_c;
  end

  // compare history: shift right, new outcome at the top
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      compare_history <= 8'h00;
    end else if (req.valid && req.op == op_comp) begin
      compare_history <= {cmp_c, compare_history[7:1]};
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // each compare moves the older entries down one place
  a_hist_shift: assert property (@(posedge clk) disable iff (!reset_n)
    (req.valid && req.op == op_comp) |=>
      compare_history[6:0] == $past(compare_history[7:1]))
    else $error("history not shifted");
  // newest entry is the and of the inverted zero and negative flags
  a_hist_top: assert property (@(posedge clk) disable iff (!reset_n)
    (req.valid && req.op == op_comp) |=>
      compare_history[7] == (!flags.zero && !flags.neg))
    else $error("history top wrong");
  // a compare leaves the register file alone
  a_comp_nowrite: assert property (@(posedge clk) disable iff (!reset_n)
    (req.valid && req.op == op_comp) |=>
      !dest_we)
    else $error("compare wrote result");
  // a nan in x gives all ones and invalid on every op but compare
  a_nan_ones: assert property (@(posedge clk) disable iff (!reset_n)
    (req.valid && req.op != op_comp && nan_x) |=>
      dest_reg == `FA_ALL_ONES && flags.inv)
    else $error("nan result not all ones");
  // nothing in this slice produces a carry
  a_carry_clear: assert property (@(posedge clk) disable iff (!reset_n)
    req.valid |=>
      !flags.carry)
    else $error("carry set");
  // abs clears the sign and records the old one
  a_abs_sign: assert property (@(posedge clk) disable iff (!reset_n)
    (req.valid && req.op == op_abs && !nan_x) |=>
      !dest_reg[39] && flags.sgn == $past(sx))
    else $error("abs sign wrong");
  // an underflow always leaves a flushed zero behind
  a_unf_zero: assert property (@(posedge clk) disable iff (!reset_n)
    flags.unf |->
      flags.zero && dest_reg[38:0] == 39'h0)
    else $error("underflow not flushed");
  // negate flips the sign of any operand that is neither nan nor zero
  a_neg_flip: assert property (@(posedge clk) disable iff (!reset_n)
    (req.valid && req.op == op_neg && !nan_x && !zx) |=>
      dest_reg[39] != $past(sx))
    else $error("negate sign wrong");
  // abs ops stay positive unless a nan or two infinities give the all-ones answer
  a_abs_ops_pos: assert property (@(posedge clk) disable iff (!reset_n)
    (req.valid && req.op inside {op_abs_add, op_abs_sub} && !nan_x && !nan_y
      && !(inf_x && inf_y)) |=>
      !dest_reg[39] && !flags.neg)
    else $error("abs op negative");
  // overflow gives infinity when rounding to nearest, largest normal on truncation
  a_ovf_special: assert property (@(posedge clk) disable iff (!reset_n)
    (req.valid && req.op != op_comp) |=>
      !flags.ovf || dest_reg[38:0] == ($past(mode_control_word[`FA_MODE_TRUNC]) ?
                                       `FA_LARGEST_NORMAL_VALUE_MAG : `FA_INF_MAG))
    else $error("overflow value wrong");
  // zero flag matches a zero magnitude after the add-type operations
  a_zero_flag: assert property (@(posedge clk) disable iff (!reset_n)
    (req.valid && req.op inside {op_add, op_sub, op_abs_add, op_abs_sub, op_avg}) |=>
      flags.zero == (dest_reg[38:0] == 39'h0))
    else $error("zero flag wrong");
endmodule // float_alu_arith_compare
`default_nettype wire

// File: testbench/float_alu_regfile_model.sv
/*
 * register file stand-in for the floating-point alu: latches each result
 * the alu writes and counts the writes.
 * assumes dest_we is a one-cycle pulse on the core clock.
 */
`default_nettype none
module float_alu_regfile_model (
  // core clock
  input  wire logic        clk,
  // write port from the alu
  input  wire logic        dest_we,
  input  wire logic [39:0] dest_reg,
  // observed state
  output var  logic [39:0] last_wr,
  output var  logic [15:0] n_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // write capture
  // ****************************************
  initial begin
    last_wr = 40'h0;
    n_wr    = 16'h0;
  end
  // take a result only on the write pulse, as the real file does
  always @(posedge clk) begin
    if (dest_we === 1'b1) begin
      last_wr <= dest_reg;
      n_wr    <= n_wr + 16'h1;
    end
  end
endmodule // float_alu_regfile_model
`default_nettype wire

// File: testbench/float_alu_arith_compare_tb.sv
/*
 * bench for the floating-point alu slice: a table of requests issued
 * back to back, then idle, mid-run reset and history restart.
 * assumes the alu answers one cycle after it takes a request.
 */
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module float_alu_arith_compare_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import float_alu_pkg::*;
  // ****************************************
  // signals and constants
  // ****************************************
  typedef struct packed {
    fp_op_e op; logic [1:0] md; logic [39:0] x; logic [39:0] y;
    logic [39:0] r; logic [6:0] f; logic [6:0] m;
  } row_s;
  localparam logic [39:0] one = 40'h3f_8000_0000, two = 40'h40_0000_0000;
  localparam logic [39:0] thr = 40'h40_4000_0000, mone = 40'hbf_8000_0000;
  localparam logic [39:0] mx = 40'h7f_7fff_ffff, mmx = 40'hff_7fff_ffff;
  localparam logic [39:0] inf = 40'h7f_8000_0000, minf = 40'hff_8000_0000;
  localparam logic [39:0] nan = 40'h7f_c000_0000, ones = 40'hff_ffff_ffff;
  localparam logic [39:0] hlf = 40'h3f_c000_0000, lo8 = 40'h3f_8000_00c0;
  localparam logic [39:0] z = 40'h0;
  // sign of an all-ones answer is not checked: mask 7b drops the neg flag
  localparam row_s rows [32] = '{
    '{op_add, 2'h0, one, two, thr, 7'h00, 7'h7f},
    '{op_sub, 2'h0, one, two, mone, 7'h04, 7'h7f},
    '{op_abs_sub, 2'h0, one, two, one, 7'h00, 7'h7f},
    '{op_abs_add, 2'h0, mone, 40'hc0_0000_0000, thr, 7'h00, 7'h7f},
    '{op_avg, 2'h0, one, two, hlf, 7'h00, 7'h7f},
    '{op_add, 2'h0, mx, mx, inf, 7'h02, 7'h7f},
    '{op_add, 2'h1, mx, mx, mx, 7'h02, 7'h7f},
    '{op_sub, 2'h0, mmx, mx, minf, 7'h06, 7'h7f},
    '{op_abs_sub, 2'h1, mmx, mx, mx, 7'h02, 7'h7f},
    '{op_add, 2'h0, nan, one, ones, 7'h20, 7'h7b},
    '{op_abs_add, 2'h0, inf, minf, ones, 7'h20, 7'h7b},
    '{op_sub, 2'h0, inf, inf, ones, 7'h20, 7'h7b},
    '{op_abs_sub, 2'h0, minf, minf, ones, 7'h20, 7'h7b},
    '{op_avg, 2'h0, one, nan, ones, 7'h20, 7'h7b},
    '{op_add, 2'h0, 40'h00_0000_0001, one, one, 7'h00, 7'h7f},
    '{op_add, 2'h0, 40'h00_8000_0001, 40'h80_8000_0000, z, 7'h41, 7'h7f},
    '{op_add, 2'h2, lo8, z, 40'h3f_8000_0100, 7'h00, 7'h7f},
    '{op_add, 2'h3, lo8, z, one, 7'h00, 7'h7f},
    '{op_add, 2'h0, lo8, z, lo8, 7'h00, 7'h7f},
    '{op_round, 2'h0, lo8, z, 40'h3f_8000_0100, 7'h00, 7'h7f},
    '{op_round, 2'h1, lo8, z, one, 7'h00, 7'h7f},
    '{op_round, 2'h0, 40'h7f_7fff_ffc0, z, inf, 7'h02, 7'h7f},
    '{op_neg, 2'h0, one, z, mone, 7'h04, 7'h7f},
    '{op_neg, 2'h0, 40'h00_0000_0001, z, 40'h80_0000_0000, 7'h01, 7'h7b},
    '{op_abs, 2'h0, mone, z, one, 7'h10, 7'h7f},
    '{op_abs, 2'h0, 40'h80_0000_0001, z, z, 7'h11, 7'h7f},
    '{op_pass, 2'h0, hlf, z, hlf, 7'h00, 7'h7f},
    '{op_pass, 2'h0, nan, z, ones, 7'h20, 7'h7b},
    '{op_comp, 2'h0, one, two, z, 7'h04, 7'h7f},
    '{op_comp, 2'h0, two, two, z, 7'h01, 7'h7f},
    '{op_comp, 2'h0, two, one, z, 7'h00, 7'h7f},
    '{op_comp, 2'h0, nan, one, z, 7'h20, 7'h7f}
  };
  logic        clk     = 1'b0;  // core clock
  logic        reset_n = 1'b0;  // async reset, active low
  alu_req_s    req;             // request to the alu
  logic [1:0]  mode;            // rounding mode and boundary
  logic        dest_we;         // write pulse
  logic [39:0] dest_reg;        // result
  alu_flags_s  flags;           // status flags
  logic [7:0]  hist;            // compare history
  logic [39:0] last_wr;         // last value the file took
  logic [15:0] n_wr;            // writes seen by the file
  logic [39:0] er = 40'h0;      // expected result
  logic [7:0]  eh = 8'h0;       // expected history
  logic [15:0] nw = 16'h0;      // expected write count
  logic [39:0] ew = 40'h0;      // expected file contents, kept over reset
  int          n_mismatch = 0;  // mismatches
  int          num_checks = 0;  // comparisons
  // ****************************************
  // clock, design and partner
  // ****************************************
  always #12.5 clk = ~clk;
  float_alu_arith_compare u_float_alu_arith_compare (
    .clk(clk), .reset_n(reset_n), .req(req), .mode_control_word(mode),
    .dest_we(dest_we), .dest_reg(dest_reg), .flags(flags), .compare_history(hist)
  );
  float_alu_regfile_model u_float_alu_regfile_model (
    .clk(clk), .dest_we(dest_we), .dest_reg(dest_reg), .last_wr(last_wr), .n_wr(n_wr)
  );
  // ****************************************
  // tasks
  // ****************************************
  task automatic drive(input row_s w);
    req  = '{1'b1, w.op, w.x, w.y};
    mode = w.md;
  endtask
  // compare answers one cycle after the request was taken
  task automatic check(input row_s w);
    logic gt;
    // the file takes a result one edge after it appears: it holds the write before
    `CHK("file", ew, last_wr)
    if (w.op == op_comp) begin
      // top entry is the and of the inverted zero and negative flags
      gt = ~w.f[0] & ~w.f[2];
      eh = {gt, eh[7:1]};
      `CHK("dest_we", 1'b0, dest_we)
    end else begin
      er = w.r;
      ew = w.r;
      nw = nw + 16'h1;
      `CHK("dest_we", 1'b1, dest_we)
    end
    `CHK("dest_reg", er, dest_reg)
    `CHK("flags", w.f & w.m, 7'(flags) & w.m)
    `CHK("history", eh, hist)
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    req  = '0;
    mode = 2'h0;
    repeat (10) @(posedge clk);
    #2 reset_n = 1'b1;
    // every row follows the last one with no gap
    foreach (rows[i]) begin
      drive(rows[i]);
      @(posedge clk);
      #2 check(rows[i]);
    end
    // idle cycle: no write, result holds
    req.valid = 1'b0;
    @(posedge clk);
    #2 `CHK("idle_we", 1'b0, dest_we)
    `CHK("idle_reg", er, dest_reg)
    // reset in mid-run clears result, flags and history at once
    reset_n = 1'b0;
    #2 `CHK("rst_reg", 40'h0, dest_reg)
    `CHK("rst_flags", 7'h0, 7'(flags))
    `CHK("rst_hist", 8'h0, hist)
    er = 40'h0;
    eh = 8'h0;
    @(posedge clk);
    #2 reset_n = 1'b1;
    drive(rows[30]);
    @(posedge clk);
    #2 check(rows[30]);
    `CHK("writes", nw, n_wr)
    give_verdict();
  end
  // watchdog: the table takes about a microsecond
  initial begin
    #20us;
    n_mismatch++;
    give_verdict();
  end
endmodule // float_alu_arith_compare_tb
`default_nettype wire
